/* File: rtl/msr_pkg.sv */
// package for the multi-source reset generator: register map, timing, defaults
// assumes a 20 MHz system clock; the serial port runs on its own clock
package msr_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  // register byte addresses within the pointer space
  localparam logic [10:0] ADDR_PULSE = 11'h0C0;
  localparam logic [10:0] ADDR_FOURTH = 11'h0C2;
  localparam logic [10:0] ADDR_WDOG = 11'h0C3;
  localparam logic [10:0] ADDR_HOLD = 11'h0C4;
  // values after reset
  localparam logic [7:0] RST_PULSE = 8'h67;
  localparam logic [7:0] RST_FOURTH = 8'hE9;
  localparam logic [7:0] RST_WDOG = 8'h4D;
  localparam logic [7:0] RST_HOLD = 8'h17;
  // step of each setting, in nanoseconds
  localparam longint unsigned PULSE_STEP_NS = 1440000;
  localparam longint unsigned FOURTH_STEP_NS = 2880000;
  localparam longint unsigned WDOG_STEP_NS = 5120000;
  localparam longint unsigned HOLD_STEP_NS = 599040000;
  // cycles per step (rounded down as a nominal duration)
  localparam int unsigned PULSE_STEP_CYC = int'(PULSE_STEP_NS * CLK_HZ / 64'd1000000000);
  localparam int unsigned FOURTH_STEP_CYC = int'(FOURTH_STEP_NS * CLK_HZ / 64'd1000000000);
  localparam int unsigned WDOG_STEP_CYC = int'(WDOG_STEP_NS * CLK_HZ / 64'd1000000000);
  localparam int unsigned HOLD_STEP_CYC = int'(HOLD_STEP_NS * CLK_HZ / 64'd1000000000);
  // internal watchdog pulse half period, in nanoseconds
  localparam longint unsigned WDGEN_HALF_NS = 50000000;
  localparam int unsigned WDGEN_HALF_CYC = int'(WDGEN_HALF_NS * CLK_HZ / 64'd1000000000);
  // control code of the serial port
  localparam logic [3:0] CTRL_CODE = 4'h0;
  typedef enum logic [1:0] {MSR_SRC_NONE, MSR_SRC_MAN, MSR_SRC_VOLTAGE_MONITOR_SELECT, MSR_SRC_WDOG} msr_src_t;
endpackage : msr_pkg

/* File: rtl/msr_i2c_slave.sv */
// serial register port of the reset generator, clocked by the serial clock pin
// assumes the bus master keeps data stable while the serial clock is high
`timescale 1ns/1ns
`default_nettype none
module msr_i2c_slave (
  input wire logic i_scl,
  input wire logic i_rst,
  input wire logic i_sda,
  output logic o_sda_oe,
  input wire logic [7:0] i_rd_data,
  output logic [10:0] o_ptr,
  output logic [7:0] o_wr_data,
  output logic o_wr_tog
);
  typedef enum logic [2:0] {MSR_I_IDLE, MSR_I_CTRL, MSR_I_WADDR, MSR_I_DATA, MSR_I_READ,
                            MSR_I_SEND} msr_i_t;
  msr_i_t st_reg;
  logic [7:0] sh_reg;
  logic [3:0] bit_reg;
  logic start_tog_reg;
  logic stop_tog_reg;
  logic start_seen_reg;
  logic stop_seen_reg;
  logic ack_reg;
  logic tx_reg;
  logic [7:0] tx_sh_reg;
  logic [2:0] blk_reg;
  logic [7:0] word_next;
  logic ctrl_ok;
  logic start_hit;
  logic stop_hit;
  // start and stop flip a toggle on a data edge while the clock is high; the clock side
  // compares toggles instead of clearing a flag, so each flop keeps a single clock
  always_ff @(negedge i_sda or posedge i_rst) begin
    if (i_rst) start_tog_reg <= 1'b0;
    else if (i_scl) start_tog_reg <= ~start_tog_reg;
  end
  always_ff @(posedge i_sda or posedge i_rst) begin
    if (i_rst) stop_tog_reg <= 1'b0;
    else if (i_scl) stop_tog_reg <= ~stop_tog_reg;
  end
  assign word_next = {sh_reg[6:0], i_sda};
  assign ctrl_ok = (sh_reg[6:3] == msr_pkg::CTRL_CODE);
  assign start_hit = start_tog_reg ^ start_seen_reg;
  assign stop_hit = stop_tog_reg ^ stop_seen_reg;
  // toggles taken as seen at every rising clock edge
  always_ff @(posedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
    end else begin
      start_seen_reg <= start_tog_reg;
      stop_seen_reg <= stop_tog_reg;
    end
  end
  // receive side on the rising clock edge; a start (even repeated) restarts decoding
  always_ff @(posedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= MSR_I_IDLE;
      sh_reg <= 8'h00;
      bit_reg <= 4'h0;
      o_ptr <= 11'h000;
      o_wr_data <= 8'h00;
      o_wr_tog <= 1'b0;
      blk_reg <= 3'h0;
    end else if (start_hit) begin
      // first control bit; a repeated start drops the write but keeps the pointer
      st_reg <= MSR_I_CTRL;
      sh_reg <= {7'h00, i_sda};
      bit_reg <= 4'h1;
    end else if (stop_hit || st_reg == MSR_I_IDLE) begin
      st_reg <= MSR_I_IDLE;
    end else if (bit_reg == 4'h8) begin
      // ninth bit is the acknowledge slot
      bit_reg <= 4'h0;
      if (st_reg == MSR_I_READ) st_reg <= MSR_I_SEND;
      else if (st_reg == MSR_I_SEND && i_sda) st_reg <= MSR_I_IDLE; // master wants no more
    end else begin
      sh_reg <= word_next;
      bit_reg <= bit_reg + 4'h1;
      if (bit_reg == 4'h7) begin
        unique case (st_reg)
          MSR_I_CTRL: begin
            // control byte: code, block bits, read/write
            if (ctrl_ok) begin
              blk_reg <= sh_reg[2:0];
              st_reg <= i_sda ? MSR_I_READ : MSR_I_WADDR;
            end else st_reg <= MSR_I_IDLE;
          end
          MSR_I_WADDR: begin
            o_ptr <= {blk_reg, word_next};
            st_reg <= MSR_I_DATA;
          end
          MSR_I_DATA: begin
            o_wr_data <= word_next;
            o_wr_tog <= ~o_wr_tog; // committed with the acknowledge
          end
          MSR_I_IDLE, MSR_I_READ, MSR_I_SEND: st_reg <= st_reg;
        endcase
      end
    end
  end
  // drive side on the falling clock edge: acknowledge and read data
  always_ff @(negedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      ack_reg <= 1'b0;
      tx_reg <= 1'b0;
      tx_sh_reg <= 8'h00;
    end else begin
      ack_reg <= (bit_reg == 4'h8) && (st_reg == MSR_I_WADDR || st_reg == MSR_I_DATA ||
                 st_reg == MSR_I_READ);
      if (st_reg == MSR_I_SEND && bit_reg == 4'h0) begin
        tx_reg <= 1'b1;
        tx_sh_reg <= i_rd_data;
      end else if (st_reg == MSR_I_SEND && bit_reg != 4'h8) begin
        tx_sh_reg <= {tx_sh_reg[6:0], 1'b1};
      end else tx_reg <= 1'b0;
    end
  end
  // open drain: enable pulls the line low
  assign o_sda_oe = ack_reg | (tx_reg & ~tx_sh_reg[7]);
endmodule : msr_i2c_slave
`default_nettype wire

/* File: rtl/msr_top.sv */
// multi-source reset generator: manual, voltage and watchdog sources plus serial settings
// assumes a 20 MHz system clock and an undervoltage comparator flag as a pin input
// Overview of operation
// - manual mode: both buttons held together for the hold time gives reset
// - voltage mode: monitored input below one volt gives reset
// - watchdog mode: no input activity for the timeout gives reset
// - each source works only while its select input is low
// - an internal watchdog pulse output is provided for looping back
// - reset pulse width defaults to about 148 ms and is reprogrammable
// - control byte holds code, three block bits and read/write
// - device acknowledges control byte; word address follows except current read
// - pointer is block bits above the eight word address bits
// - byte write is control, address, data, stop, each acknowledged
// - written byte commits when its acknowledge is driven
// - repeated start after address aborts write but keeps pointer
// - current read: control byte with read bit, ack, eight data bits
// - pulse setting at 0xC0, 1 to 255, default 103, 1.44 ms step
// - fourth delay at 0xC2, 1 to 255, default 233, 2.88 ms step
// - watchdog timeout at 0xC3, 1 to 255, default 77, 5.12 ms step
// - hold setting at 0xC4, 1 to 255, default 23, 599.04 ms step
`timescale 1ns/1ns
`default_nettype none
module msr_top #(
  parameter int unsigned PULSE_STEP = msr_pkg::PULSE_STEP_CYC,
  parameter int unsigned WDOG_STEP = msr_pkg::WDOG_STEP_CYC,
  parameter int unsigned HOLD_STEP = msr_pkg::HOLD_STEP_CYC,
  parameter int unsigned WDGEN_HALF = msr_pkg::WDGEN_HALF_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  output logic o_sda,
  input wire logic i_first_push_button,
  input wire logic i_second_push_button,
  input wire logic i_voltage_below_1v,
  input wire logic i_watchdog_pulse_input,
  input wire logic i_voltage_monitor_select_n,
  input wire logic i_watchdog_select_n,
  input wire logic i_manual_select_n,
  output logic o_internal_watchdog_output,
  output logic o_reset_indicator_output
);
  localparam int W = 32;
  logic [7:0] reset_pulse_count_reg;
  logic [7:0] fourth_delay_count_reg;
  logic [7:0] watchdog_timeout_count_reg;
  logic [7:0] manual_hold_count_reg;
  logic [10:0] ptr;
  logic [7:0] wr_data;
  logic wr_tog;
  logic [7:0] rd_data;
  logic [2:0] tog_sync_reg;
  logic wr_pulse;
  logic [2:0] s1_reg, s2_reg, vl_reg, wd_reg, sv_reg, sw_reg, sm_reg;
  logic b1, b2, vlow, wdin, sel_v, sel_w, sel_m;
  logic wdin_d_reg;
  logic [W-1:0] hold_cnt_reg, wdog_cnt_reg, pulse_cnt_reg, gen_cnt_reg;
  logic both_pressed, hold_armed_reg, hold_fire, wdog_fire, volt_fire;
  logic trig;
  logic pulse_active_reg;
  msr_pkg::msr_src_t src_reg;
  // serial register port on the serial clock domain
  msr_i2c_slave u_i2c (
    .i_scl(i_scl),
    .i_rst(i_rst),
    .i_sda(i_sda),
    .o_sda_oe(o_sda_oe),
    .i_rd_data(rd_data),
    .o_ptr(ptr),
    .o_wr_data(wr_data),
    .o_wr_tog(wr_tog)
  );
  // open drain line is only ever pulled low
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_sda <= 1'b0;
    else o_sda <= 1'b0;
  end
  // read mux; pointer and data words are quasi-static while the toggle settles
  assign rd_data = (ptr == msr_pkg::ADDR_PULSE) ? reset_pulse_count_reg :
                   (ptr == msr_pkg::ADDR_FOURTH) ? fourth_delay_count_reg :
                   (ptr == msr_pkg::ADDR_WDOG) ? watchdog_timeout_count_reg :
                   (ptr == msr_pkg::ADDR_HOLD) ? manual_hold_count_reg : 8'h00;
  // write toggle crosses via three flops; a change counts once the last two differ
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) tog_sync_reg <= 3'h0;
    else tog_sync_reg <= {tog_sync_reg[1:0], wr_tog};
  end
  assign wr_pulse = tog_sync_reg[2] ^ tog_sync_reg[1];
  // settings registers; zero is outside the range and is ignored
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      reset_pulse_count_reg <= msr_pkg::RST_PULSE;
      fourth_delay_count_reg <= msr_pkg::RST_FOURTH;
      watchdog_timeout_count_reg <= msr_pkg::RST_WDOG;
      manual_hold_count_reg <= msr_pkg::RST_HOLD;
    end else if (wr_pulse && wr_data != 8'h00) begin
      if (ptr == msr_pkg::ADDR_PULSE) reset_pulse_count_reg <= wr_data;
      if (ptr == msr_pkg::ADDR_FOURTH) fourth_delay_count_reg <= wr_data;
      if (ptr == msr_pkg::ADDR_WDOG) watchdog_timeout_count_reg <= wr_data;
      if (ptr == msr_pkg::ADDR_HOLD) manual_hold_count_reg <= wr_data;
    end
  end
  // pin synchronisers: three flops, a level counts when stages two and three agree
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_reg <= 3'h7;
      s2_reg <= 3'h7;
      vl_reg <= 3'h0;
      wd_reg <= 3'h0;
      sv_reg <= 3'h7;
      sw_reg <= 3'h7;
      sm_reg <= 3'h7;
    end else begin
      s1_reg <= {s1_reg[1:0], i_first_push_button};
      s2_reg <= {s2_reg[1:0], i_second_push_button};
      vl_reg <= {vl_reg[1:0], i_voltage_below_1v};
      wd_reg <= {wd_reg[1:0], i_watchdog_pulse_input};
      sv_reg <= {sv_reg[1:0], i_voltage_monitor_select_n};
      sw_reg <= {sw_reg[1:0], i_watchdog_select_n};
      sm_reg <= {sm_reg[1:0], i_manual_select_n};
    end
  end
  // filtered levels hold their last agreed value while stages disagree
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      b1 <= 1'b1;
      b2 <= 1'b1;
      vlow <= 1'b0;
      wdin <= 1'b0;
      sel_v <= 1'b0;
      sel_w <= 1'b0;
      sel_m <= 1'b0;
      wdin_d_reg <= 1'b0;
    end else begin
      if (s1_reg[1] == s1_reg[2]) b1 <= s1_reg[2];
      if (s2_reg[1] == s2_reg[2]) b2 <= s2_reg[2];
      if (vl_reg[1] == vl_reg[2]) vlow <= vl_reg[2];
      if (wd_reg[1] == wd_reg[2]) wdin <= wd_reg[2];
      if (sv_reg[1] == sv_reg[2]) sel_v <= ~sv_reg[2]; // active when low
      if (sw_reg[1] == sw_reg[2]) sel_w <= ~sw_reg[2];
      if (sm_reg[1] == sm_reg[2]) sel_m <= ~sm_reg[2];
      wdin_d_reg <= wdin;
    end
  end
  // buttons pull low when pressed
  assign both_pressed = sel_m && !b1 && !b2;
  // manual hold timer: reloads the setting until both buttons go down, then counts down
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hold_cnt_reg <= '0;
      hold_armed_reg <= 1'b0;
    end else if (!both_pressed) begin
      hold_cnt_reg <= W'(manual_hold_count_reg) * W'(HOLD_STEP);
      hold_armed_reg <= 1'b1;
    end else if (hold_cnt_reg != '0) begin
      hold_cnt_reg <= hold_cnt_reg - 1'b1;
    end else hold_armed_reg <= 1'b0;
  end
  assign hold_fire = both_pressed && hold_cnt_reg == '0 && hold_armed_reg;
  // watchdog timeout: any edge on the input restarts it from the fresh setting
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) wdog_cnt_reg <= '0;
    else if (!sel_w || wdin != wdin_d_reg || wdog_fire)
      wdog_cnt_reg <= W'(watchdog_timeout_count_reg) * W'(WDOG_STEP);
    else if (wdog_cnt_reg != '0) wdog_cnt_reg <= wdog_cnt_reg - 1'b1;
  end
  assign wdog_fire = sel_w && wdog_cnt_reg == W'(1) && wdin == wdin_d_reg;
  assign volt_fire = sel_v && vlow;
  assign trig = hold_fire | wdog_fire | volt_fire;
  // reset pulse: width from the pulse setting; voltage low keeps it retriggered
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pulse_cnt_reg <= '0;
      pulse_active_reg <= 1'b0;
      src_reg <= msr_pkg::MSR_SRC_NONE;
    end else if (trig) begin
      pulse_cnt_reg <= W'(reset_pulse_count_reg) * W'(PULSE_STEP);
      pulse_active_reg <= 1'b1;
      src_reg <= volt_fire ? msr_pkg::MSR_SRC_VOLTAGE_MONITOR_SELECT :
                 wdog_fire ? msr_pkg::MSR_SRC_WDOG : msr_pkg::MSR_SRC_MAN;
    end else if (pulse_cnt_reg > W'(1)) pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
    else begin
      pulse_cnt_reg <= '0;
      pulse_active_reg <= 1'b0;
    end
  end
  // indicator follows the pulse whatever the source
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_reset_indicator_output <= 1'b0;
    else o_reset_indicator_output <= pulse_active_reg;
  end
  // internal watchdog pulse generator, free running square wave
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      gen_cnt_reg <= '0;
      o_internal_watchdog_output <= 1'b0;
    end else if (gen_cnt_reg >= W'(WDGEN_HALF - 1)) begin
      gen_cnt_reg <= '0;
      o_internal_watchdog_output <= ~o_internal_watchdog_output;
    end else gen_cnt_reg <= gen_cnt_reg + 1'b1;
  end
  // checks
  property p_ind_follows;
    @(posedge i_clk) disable iff (i_rst) pulse_active_reg |=> o_reset_indicator_output;
  endproperty
  a_ind_follows: assert property (p_ind_follows) else $error("indicator missed pulse");
  property p_volt;
    @(posedge i_clk) disable iff (i_rst) volt_fire |=> pulse_active_reg;
  endproperty
  a_volt: assert property (p_volt) else $error("voltage reset missing");
  property p_sel;
    @(posedge i_clk) disable iff (i_rst) trig |-> (sel_v || sel_w || sel_m);
  endproperty
  a_sel: assert property (p_sel) else $error("reset from disabled source");
  property p_hold;
    @(posedge i_clk) disable iff (i_rst) hold_fire |-> both_pressed;
  endproperty
  a_hold: assert property (p_hold) else $error("manual reset without buttons");
  property p_wdog_reload;
    @(posedge i_clk) disable iff (i_rst) (sel_w && wdin != wdin_d_reg) |=> !wdog_fire;
  endproperty
  a_wdog_reload: assert property (p_wdog_reload) else $error("watchdog not restarted");
  property p_pulse_load;
    @(posedge i_clk) disable iff (i_rst)
      trig |=> pulse_cnt_reg == W'($past(reset_pulse_count_reg)) * W'(PULSE_STEP);
  endproperty
  a_pulse_load: assert property (p_pulse_load) else $error("pulse width wrong");
  property p_write;
    @(posedge i_clk) disable iff (i_rst)
      (wr_pulse && wr_data != 8'h00 && ptr == msr_pkg::ADDR_PULSE) |=> reset_pulse_count_reg == $past(wr_data);
  endproperty
  a_write: assert property (p_write) else $error("setting not written");
  property p_nonzero;
    @(posedge i_clk) disable iff (i_rst) watchdog_timeout_count_reg != 8'h00 && manual_hold_count_reg != 8'h00;
  endproperty
  a_nonzero: assert property (p_nonzero) else $error("setting out of range");
  c_volt: cover property (@(posedge i_clk) disable iff (i_rst) volt_fire);
  c_wdog: cover property (@(posedge i_clk) disable iff (i_rst) wdog_fire);
  c_hold: cover property (@(posedge i_clk) disable iff (i_rst) hold_fire);
  c_write: cover property (@(posedge i_clk) disable iff (i_rst) wr_pulse);
endmodule : msr_top
`default_nettype wire

/* File: verif/msr_bus_master_model.sv */
// serial bus master model for the reset generator register port
// assumes the bench combines its data drive with the device pull-down and a pull-up
`timescale 1ns/1ns
`default_nettype none
module msr_bus_master_model (
  output var logic o_scl,
  output var logic o_sda,
  input wire logic i_sda_line
);
  // bus idle: clock stands high outside frames, data released to the pull-up
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // start or repeated start: data falls while the clock is high
  task automatic start_cond();
    o_sda = 1'b1;
    #1;
    o_scl = 1'b1;
    #2;
    o_sda = 1'b0;
    #2;
    o_scl = 1'b0;
    #1;
  endtask : start_cond
  // stop: data rises while the clock is high, then the clock stands still
  task automatic stop_cond();
    o_sda = 1'b0;
    #1;
    o_scl = 1'b1;
    #2;
    o_sda = 1'b1;
    #3;
  endtask : stop_cond
  // one 6 ns bit; data changes only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    o_sda = b;
    #1;
    o_scl = 1'b1;
    #2;
    s = i_sda_line;
    #1;
    o_scl = 1'b0;
    #2;
  endtask : bit_io
  // eight bits, most significant first, then the ninth bit released for the answer
  task automatic byte_io(input logic [7:0] b, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r[i]);
    end
    bit_io(1'b1, ack);
  endtask : byte_io
  // byte write: control, address, data, stop; ok when every byte was acknowledged
  task automatic write_reg(input logic [3:0] code, input logic [10:0] addr,
                           input logic [7:0] data, output logic ok);
    logic [7:0] r;
    logic a0;
    logic a1;
    logic a2;
    start_cond();
    byte_io({code, addr[10:8], 1'b0}, r, a0);
    byte_io(addr[7:0], r, a1);
    byte_io(data, r, a2);
    stop_cond();
    ok = !a0 && !a1 && !a2;
  endtask : write_reg
  // random read: address set by a write header, repeated start, read control, one byte
  task automatic read_reg(input logic [10:0] addr, output logic [7:0] data,
                          output logic ok);
    logic [7:0] r;
    logic a0;
    logic a1;
    logic a2;
    logic nk;
    start_cond();
    byte_io({msr_pkg::CTRL_CODE, addr[10:8], 1'b0}, r, a0);
    byte_io(addr[7:0], r, a1);
    start_cond();
    byte_io({msr_pkg::CTRL_CODE, addr[10:8], 1'b1}, r, a2);
    byte_io(8'hFF, data, nk);
    stop_cond();
    ok = !a0 && !a1 && !a2;
  endtask : read_reg
endmodule : msr_bus_master_model
`default_nettype wire

/* File: verif/tb_msr_top.sv */
// self-checking bench of the reset generator: register port, three sources, pulse width
// assumes shortened step parameters; the serial clock runs only inside frames
`timescale 1ns/1ns
`default_nettype none
module tb_msr_top;
  localparam int PS = 10;
  localparam int WS = 20;
  localparam int HS = 50;
  localparam int GH = 30;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic b1_n = 1'b1;
  logic b2_n = 1'b1;
  logic v_low = 1'b0;
  logic wd_ext = 1'b0;
  logic loop = 1'b0;
  logic vsel_n = 1'b1;
  logic wsel_n = 1'b1;
  logic msel_n = 1'b1;
  logic scl;
  logic sda_drv;
  logic sda_oe;
  logic sda_o;
  logic wd_gen;
  logic ind;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  // wired-and data line: the device only ever pulls low
  wire sda_line = sda_drv & (sda_oe ? sda_o : 1'b1);
  wire watchdog_pulse_input = loop ? wd_gen : wd_ext;
  msr_top #(.PULSE_STEP(PS), .WDOG_STEP(WS), .HOLD_STEP(HS), .WDGEN_HALF(GH)) msr_top_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_line), .o_sda_oe(sda_oe),
    .o_sda(sda_o), .i_first_push_button(b1_n), .i_second_push_button(b2_n),
    .i_voltage_below_1v(v_low), .i_watchdog_pulse_input(watchdog_pulse_input),
    .i_voltage_monitor_select_n(vsel_n), .i_watchdog_select_n(wsel_n),
    .i_manual_select_n(msel_n), .o_internal_watchdog_output(wd_gen),
    .o_reset_indicator_output(ind));
  msr_bus_master_model msr_bus_master_model_inst (
    .o_scl(scl), .o_sda(sda_drv), .i_sda_line(sda_line));
  always #25 i_clk = ~i_clk;
  // hang guard, well above the roughly 9000 cycles the tests take
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // pin inputs set after this task move 2 ns after a rising edge
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask : step
  task automatic wait_ind(input logic lvl, input int lim, output int n);
    n = 0;
    while (ind !== lvl && n < lim) begin
      step(1);
      n++;
    end
  endtask : wait_ind
  task automatic rd(input logic [10:0] a, input logic [7:0] exp, input string name);
    logic [7:0] d;
    logic ok;
    // let a preceding write cross into the system clock before the pointer moves
    step(8);
    msr_bus_master_model_inst.read_reg(a, d, ok);
    check({name, " ack"}, ok, 1'b1);
    check(name, d, exp);
  endtask : rd
  task automatic t_regs();
    rd(msr_pkg::ADDR_PULSE, msr_pkg::RST_PULSE, "pulse default");
    rd(msr_pkg::ADDR_FOURTH, msr_pkg::RST_FOURTH, "fourth default");
    rd(msr_pkg::ADDR_WDOG, msr_pkg::RST_WDOG, "wdog default");
    rd(msr_pkg::ADDR_HOLD, msr_pkg::RST_HOLD, "hold default");
    rd(11'h0C1, 8'h00, "unmapped");
    rd(11'h1C0, 8'h00, "other block");
    $display("test regs done");
  endtask : t_regs
  // generator looped back keeps the watchdog quiet; half period is the chosen figure
  task automatic t_loop();
    int n;
    logic v;
    loop = 1'b1;
    wsel_n = 1'b0;
    step(2500);
    check("loop quiet", ind, 1'b0);
    @(wd_gen);
    step(1);
    v = wd_gen;
    n = 0;
    while (wd_gen === v && n < 100) begin
      step(1);
      n++;
    end
    check("gen half", n, GH - 1);
    wsel_n = 1'b1;
    loop = 1'b0;
    $display("test loop done");
  endtask : t_loop
  task automatic t_wdog();
    int n;
    logic seen;
    seen = 1'b0;
    wsel_n = 1'b0;
    for (int i = 0; i < 50; i++) begin
      step(40);
      wd_ext = ~wd_ext;
      seen = seen | ind;
    end
    check("wdog active", seen, 1'b0);
    wait_ind(1'b1, 1700, n);
    check("wdog timeout", n >= 77 * WS - 5 && n <= 77 * WS + 12, 1'b1);
    wsel_n = 1'b1;
    wait_ind(1'b0, 1200, n);
    check("default width", n >= 103 * PS - 4 && n <= 103 * PS + 2, 1'b1);
    $display("test watchdog done");
  endtask : t_wdog
  task automatic t_volt();
    int n;
    v_low = 1'b1;
    step(50);
    check("voltage_monitor_select disabled", ind, 1'b0);
    vsel_n = 1'b0;
    wait_ind(1'b1, 12, n);
    check("voltage_monitor_select fires", ind, 1'b1);
    step(200);
    check("voltage_monitor_select holds", ind, 1'b1);
    v_low = 1'b0;
    wait_ind(1'b0, 1200, n);
    check("voltage_monitor_select width", n >= 103 * PS - 2 && n <= 103 * PS + 8, 1'b1);
    vsel_n = 1'b1;
    $display("test voltage done");
  endtask : t_volt
  task automatic t_write();
    logic ok;
    msr_bus_master_model_inst.write_reg(msr_pkg::CTRL_CODE, msr_pkg::ADDR_PULSE, 8'h05, ok);
    check("write ack", ok, 1'b1);
    rd(msr_pkg::ADDR_PULSE, 8'h05, "pulse written");
    msr_bus_master_model_inst.write_reg(msr_pkg::CTRL_CODE, msr_pkg::ADDR_FOURTH, 8'hFF, ok);
    rd(msr_pkg::ADDR_FOURTH, 8'hFF, "fourth written");
    msr_bus_master_model_inst.write_reg(msr_pkg::CTRL_CODE, msr_pkg::ADDR_HOLD, 8'h00, ok);
    rd(msr_pkg::ADDR_HOLD, msr_pkg::RST_HOLD, "zero refused");
    msr_bus_master_model_inst.write_reg(4'h5, msr_pkg::ADDR_HOLD, 8'h02, ok);
    check("bad code ack", ok, 1'b0);
    msr_bus_master_model_inst.write_reg(msr_pkg::CTRL_CODE, msr_pkg::ADDR_HOLD, 8'h01, ok);
    rd(msr_pkg::ADDR_HOLD, 8'h01, "hold written");
    step(10);
    $display("test write done");
  endtask : t_write
  // new settings are picked up: hold of one step, pulse of five steps
  task automatic t_manual();
    int n;
    b1_n = 1'b0;
    b2_n = 1'b0;
    step(150);
    check("manual disabled", ind, 1'b0);
    b1_n = 1'b1;
    b2_n = 1'b1;
    msel_n = 1'b0;
    step(10);
    b1_n = 1'b0;
    b2_n = 1'b0;
    wait_ind(1'b1, 100, n);
    check("hold time", n >= HS - 2 && n <= HS + 10, 1'b1);
    wait_ind(1'b0, 100, n);
    check("new width", n >= 5 * PS - 2 && n <= 5 * PS + 1, 1'b1);
    step(200);
    check("once per press", ind, 1'b0);
    b1_n = 1'b1;
    b2_n = 1'b1;
    msel_n = 1'b1;
    $display("test manual done");
  endtask : t_manual
  initial begin
    step(2);
    i_rst = 1'b0;
    check("reset idle", ind, 1'b0);
    step(5);
    t_regs();
    t_loop();
    t_wdog();
    t_volt();
    t_write();
    t_manual();
    finish_test();
  end
endmodule : tb_msr_top
`default_nettype wire
